//--- include/hv_meas_pkg.sv
// hv_meas_pkg: register map, field layout and mode codes for the
// high-voltage measurement switch control block.
// assumes a plain address/strobe register port with 8-bit addresses.
package hv_meas_pkg;

  // register offsets
  localparam logic [7:0] meas_ctrl_addr   = 8'h00;
  localparam logic [7:0] pull_cfg_addr    = 8'h01;
  localparam logic [7:0] wake_ctrl_addr   = 8'h02;
  localparam logic [7:0] multipin_addr    = 8'h03;
  localparam logic [7:0] wake_stat0_addr  = 8'h04;
  localparam logic [7:0] wake_stat1_addr  = 8'h05;
  localparam logic [7:0] wake_lvl_addr    = 8'h06;
  localparam logic [7:0] status_addr      = 8'h07;

  // meas_ctrl fields
  localparam int meas_en_bit = 0;
  localparam int fo_test_bit = 1;

  // wake_ctrl fields
  localparam int sense_wake_bit = 0;
  localparam int timer_wake_bit = 1;
  localparam int can_wake_bit   = 2;

  // multipin control: low three bits are the pin function
  localparam logic [2:0] multipin_off  = 3'h0;
  localparam logic [2:0] multipin_fo   = 3'h1;
  localparam logic [2:0] multipin_wake = 3'h2;

  // status fields
  localparam int cmd_err_bit  = 0;
  localparam int switch_bit   = 1;
  localparam int normal_bit   = 2;

  // reset values
  localparam logic [7:0] meas_ctrl_rst = 8'h00;
  localparam logic [7:0] pull_cfg_rst  = 8'h00;
  localparam logic [7:0] wake_ctrl_rst = 8'h01;
  localparam logic [7:0] multipin_rst  = 8'h01;

  // chip modes supplied by the mode state machine
  typedef enum logic [2:0] {
    mode_init,
    mode_normal,
    mode_stop,
    mode_sleep,
    mode_restart,
    mode_failsafe
  } chip_mode_t;

endpackage

//--- rtl/pin_gate.sv
// pin_gate: one pin's input qualification, pulls and wake status.
// assumes the pin level is already synchronous to sys_clk.
`timescale 1ns/1ps
module pin_gate (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic pin_in,
  input  wire logic gate,
  input  wire logic wake_en,
  input  wire logic pull_up_cfg,
  input  wire logic pull_dn_cfg,
  input  wire logic clr_wake,
  output logic      pin_qual_ff,
  output logic      level_ff,
  output logic      wake_ff,
  output logic      pull_up_ff,
  output logic      pull_dn_ff
);
  logic prev_ff;
  logic primed_ff;
  logic edge_seen;

  // gated copy of the pin, held low while bridged
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_qual_ff <= 1'b0;
    end else begin
      pin_qual_ff <= pin_in & ~gate;
    end
  end

  // pulls forced off while bridged so the divider sees no bias
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pull_up_ff <= 1'b0;
      pull_dn_ff <= 1'b0;
    end else begin
      pull_up_ff <= pull_up_cfg & ~gate;
      pull_dn_ff <= pull_dn_cfg & ~gate;
    end
  end

  // level status frozen while gated
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= 1'b0;
    end else if (!gate) begin
      level_ff <= pin_in;
    end
  end

  // edge reference follows the pin even while gated, so that
  // opening the bridge again raises no stale edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff   <= 1'b0;
      primed_ff <= 1'b0;
    end else begin
      prev_ff   <= pin_in;
      primed_ff <= 1'b1;
    end
  end

  // first sample after reset is only a reference, never an edge
  assign edge_seen = primed_ff & ~gate & wake_en & (pin_in != prev_ff);

  // sticky wake flag, set beats clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_ff <= 1'b0;
    end else if (edge_seen) begin
      wake_ff <= 1'b1;
    end else if (clr_wake) begin
      wake_ff <= 1'b0;
    end
  end

  // no level status update from the pin while gated
  property p_frozen;
    @(posedge sys_clk) disable iff (!nrst)
      $past(gate) |-> $stable(level_ff);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("level status moved while gated");

  // wake flag only moves by a software clear while gated
  property p_wake_held;
    @(posedge sys_clk) disable iff (!nrst)
      (gate && !clr_wake) |=> $stable(wake_ff);
  endproperty
  a_wake_held: assert property (p_wake_held)
    else $error("wake status moved while gated");
endmodule

//--- rtl/sw_sync.sv
// sw_sync: one-flop registered switch drive from enable and mode.
// assumes mode_is_normal comes from the chip mode machine on sys_clk.
`timescale 1ns/1ps
module sw_sync (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic mode_is_normal,
  output logic      close_ff
);
  logic nxt_close;

  // closed only with enable and normal mode together
  assign nxt_close = enable & mode_is_normal;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      close_ff <= 1'b0;
    end else begin
      close_ff <= nxt_close;
    end
  end
endmodule

//--- rtl/hv_measure_switch_ctrl.sv
// hv_measure_switch_ctrl: control of the bridge switch between the
// high-voltage sense pin and the multipurpose pin, with the register
// port, input gating, pull control and sleep command checking.
// assumes pins and commands arrive synchronous to sys_clk and the
// chip mode machine consumes the restart request.
`timescale 1ns/1ps
module hv_measure_switch_ctrl
  import hv_meas_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata_ff,
  input  wire hv_meas_pkg::chip_mode_t chip_mode,
  input  wire logic                    sleep_cmd,
  input  wire logic                    sense_pin_in,
  input  wire logic                    multipin_in,
  input  wire logic                    fail_req,
  output logic                         pin_bridge_switch_ff,
  output logic                         restart_req_ff,
  output logic                         sleep_ok_ff,
  output logic                         fail_out_ff,
  output logic                         multipin_drive_ff,
  output logic                         sense_pull_up_ff,
  output logic                         sense_pull_dn_ff,
  output logic                         multi_pull_up_ff,
  output logic                         multi_pull_dn_ff,
  output logic                         sense_qual_ff,
  output logic                         multi_qual_ff
);
  import hv_meas_pkg::*;

  logic [7:0] meas_ctrl_ff;
  logic [7:0] sense_pull_config_ff;
  logic [7:0] wake_control_second_ff;
  logic [7:0] multipin_ff;
  logic       cmd_err_ff;
  logic       failsafe_wake_ff;
  chip_mode_t mode_prev_ff;

  logic       measure_path_enable;
  logic       is_normal;
  logic       wr_meas;
  logic       wr_multi;
  logic       enable_refused;
  logic       multi_change_err;
  logic       pin_only_sleep;
  logic       failsafe_entry;
  logic       sense_wake_eff;
  logic       multi_wake_eff;
  logic       clr_stat0;
  logic       clr_stat1;
  logic       sense_level;
  logic       multi_level;
  logic       sense_wake;
  logic       multi_wake;
  logic       sense_pu;
  logic       sense_pd;
  logic       multi_pu;
  logic       multi_pd;
  logic       nxt_err;

  assign measure_path_enable = meas_ctrl_ff[meas_en_bit];
  assign is_normal      = (chip_mode == mode_normal);
  assign wr_meas        = reg_wr && (reg_addr == meas_ctrl_addr);
  assign wr_multi       = reg_wr && (reg_addr == multipin_addr);
  assign failsafe_entry = (chip_mode == mode_failsafe) &&
                          (mode_prev_ff != mode_failsafe);

  // enable may only rise with the multipin already off
  assign enable_refused = wr_meas && reg_wdata[meas_en_bit] &&
                          !measure_path_enable &&
                          (multipin_ff[2:0] != multipin_off);
  // any multipin change while bridged is a command error
  assign multi_change_err = wr_multi && measure_path_enable &&
                            (reg_wdata != multipin_ff);

  // pin wake bits count only while not bridged
  assign sense_wake_eff = (wake_control_second_ff[sense_wake_bit] |
                           failsafe_wake_ff) & ~measure_path_enable;
  assign multi_wake_eff = (multipin_ff[2:0] == multipin_wake) &
                          ~measure_path_enable;

  // sleep left with only pin wakes that the bridge has disabled
  assign pin_only_sleep = sleep_cmd && measure_path_enable &&
    !wake_control_second_ff[timer_wake_bit] &&
    !wake_control_second_ff[can_wake_bit];

  assign clr_stat0 = reg_wr && (reg_addr == wake_stat0_addr);
  assign clr_stat1 = reg_wr && (reg_addr == wake_stat1_addr);

  // measurement control register; stored across all modes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meas_ctrl_ff <= meas_ctrl_rst;
    end else if (wr_meas && !enable_refused) begin
      meas_ctrl_ff <= reg_wdata;
    end
  end

  // pull and wake settings stay writable while bridged
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sense_pull_config_ff   <= pull_cfg_rst;
      wake_control_second_ff <= wake_ctrl_rst;
    end else if (reg_wr) begin
      if (reg_addr == pull_cfg_addr) begin
        sense_pull_config_ff <= reg_wdata;
      end
      if (reg_addr == wake_ctrl_addr) begin
        wake_control_second_ff <= reg_wdata;
      end
    end
  end

  // multipin control also stays writable; the change only raises error
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      multipin_ff <= multipin_rst;
    end else if (wr_multi) begin
      multipin_ff <= reg_wdata;
    end
  end

  // sticky command error, set wins over the clearing write
  assign nxt_err = enable_refused | multi_change_err | pin_only_sleep;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_err_ff <= 1'b0;
    end else if (nxt_err) begin
      cmd_err_ff <= 1'b1;
    end else if (reg_wr && (reg_addr == status_addr) &&
                 reg_wdata[cmd_err_bit]) begin
      cmd_err_ff <= 1'b0;
    end
  end

  // mode history for fail-safe entry detection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_prev_ff <= mode_init;
    end else begin
      mode_prev_ff <= chip_mode;
    end
  end

  // fail-safe entry while disabled arms the sense pin as wake
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      failsafe_wake_ff <= 1'b0;
    end else if (failsafe_entry && !measure_path_enable) begin
      failsafe_wake_ff <= 1'b1;
    end else if (chip_mode == mode_normal) begin
      failsafe_wake_ff <= 1'b0;
    end
  end

  // restart request or clean sleep acknowledge, one cycle each
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      restart_req_ff <= 1'b0;
      sleep_ok_ff    <= 1'b0;
    end else begin
      restart_req_ff <= pin_only_sleep;
      sleep_ok_ff    <= sleep_cmd && !pin_only_sleep;
    end
  end

  // fail output and pin drive vanish while bridged
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fail_out_ff       <= 1'b0;
      multipin_drive_ff <= 1'b0;
    end else begin
      fail_out_ff <= ~measure_path_enable &
                     (multipin_ff[2:0] == multipin_fo) &
                     (fail_req | meas_ctrl_ff[fo_test_bit]);
      multipin_drive_ff <= ~measure_path_enable &
                           (multipin_ff[2:0] != multipin_off) &
                           (multipin_ff[2:0] != multipin_wake);
    end
  end

  // pull requests from the ignored-while-bridged pull register
  assign sense_pu = sense_pull_config_ff[0];
  assign sense_pd = sense_pull_config_ff[1];
  assign multi_pu = sense_pull_config_ff[2];
  assign multi_pd = sense_pull_config_ff[3];

  // per-pin gating; bridge blocks status, pulls and inputs
  pin_gate u_sense (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .pin_in      (sense_pin_in),
    .gate        (measure_path_enable),
    .wake_en     (sense_wake_eff),
    .pull_up_cfg (sense_pu),
    .pull_dn_cfg (sense_pd),
    .clr_wake    (clr_stat0),
    .pin_qual_ff (sense_qual_ff),
    .level_ff    (sense_level),
    .wake_ff     (sense_wake),
    .pull_up_ff  (sense_pull_up_ff),
    .pull_dn_ff  (sense_pull_dn_ff)
  );

  pin_gate u_multi (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .pin_in      (multipin_in),
    .gate        (measure_path_enable),
    .wake_en     (multi_wake_eff),
    .pull_up_cfg (multi_pu),
    .pull_dn_cfg (multi_pd),
    .clr_wake    (clr_stat1),
    .pin_qual_ff (multi_qual_ff),
    .level_ff    (multi_level),
    .wake_ff     (multi_wake),
    .pull_up_ff  (multi_pull_up_ff),
    .pull_dn_ff  (multi_pull_dn_ff)
  );

  // switch is opened in fail-safe and every non-normal mode
  sw_sync u_sw (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .enable         (measure_path_enable),
    .mode_is_normal (is_normal),
    .close_ff       (pin_bridge_switch_ff)
  );

  // read mux, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        meas_ctrl_addr:  reg_rdata_ff <= meas_ctrl_ff;
        pull_cfg_addr:   reg_rdata_ff <= sense_pull_config_ff;
        wake_ctrl_addr:  reg_rdata_ff <= wake_control_second_ff;
        multipin_addr:   reg_rdata_ff <= multipin_ff;
        wake_stat0_addr: reg_rdata_ff <= {7'h00, sense_wake};
        wake_stat1_addr: reg_rdata_ff <= {7'h00, multi_wake};
        wake_lvl_addr:   reg_rdata_ff <= {6'h00, multi_level, sense_level};
        status_addr:     reg_rdata_ff <= {5'h00, is_normal,
                                          pin_bridge_switch_ff, cmd_err_ff};
        default:         reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // switch follows enable and normal mode one cycle later
  property p_switch;
    @(posedge sys_clk) disable iff (!nrst)
      ##1 pin_bridge_switch_ff == $past(measure_path_enable & is_normal);
  endproperty
  a_switch: assert property (p_switch)
    else $error("switch does not follow enable and mode");

  property p_open_off_normal;
    @(posedge sys_clk) disable iff (!nrst)
      !is_normal |=> !pin_bridge_switch_ff;
  endproperty
  a_open_off_normal: assert property (p_open_off_normal)
    else $error("switch closed outside normal mode");

  property p_kept;
    @(posedge sys_clk) disable iff (!nrst)
      (measure_path_enable && !wr_meas) |=> measure_path_enable;
  endproperty
  a_kept: assert property (p_kept)
    else $error("enable lost without a write");

  property p_pulls;
    @(posedge sys_clk) disable iff (!nrst)
      measure_path_enable |=> !(sense_pull_up_ff | sense_pull_dn_ff |
                               multi_pull_up_ff | multi_pull_dn_ff);
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("pull active while bridged");

  property p_gate_in;
    @(posedge sys_clk) disable iff (!nrst)
      measure_path_enable |=> !(sense_qual_ff | multi_qual_ff);
  endproperty
  a_gate_in: assert property (p_gate_in)
    else $error("pin input passed while bridged");

  property p_refuse;
    @(posedge sys_clk) disable iff (!nrst)
      enable_refused |=> (!measure_path_enable && cmd_err_ff);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("enable accepted with multipin on");

  sequence s_bad_sleep;
    pin_only_sleep;
  endsequence
  sequence s_restart;
    restart_req_ff && cmd_err_ff && !sleep_ok_ff;
  endsequence
  property p_sleep;
    @(posedge sys_clk) disable iff (!nrst) s_bad_sleep |=> s_restart;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("pin-only sleep not turned to restart");

  property p_multi_err;
    @(posedge sys_clk) disable iff (!nrst)
      multi_change_err |=> cmd_err_ff;
  endproperty
  a_multi_err: assert property (p_multi_err)
    else $error("multipin change while bridged not flagged");

  property p_no_fail;
    @(posedge sys_clk) disable iff (!nrst)
      measure_path_enable |=> !(fail_out_ff | multipin_drive_ff);
  endproperty
  a_no_fail: assert property (p_no_fail)
    else $error("fail or pin drive while bridged");

  property p_fs_wake;
    @(posedge sys_clk) disable iff (!nrst)
      (failsafe_entry && !measure_path_enable) |=> failsafe_wake_ff;
  endproperty
  a_fs_wake: assert property (p_fs_wake)
    else $error("sense wake not armed on fail-safe entry");
endmodule

//--- test/host_bus_model.sv
// host_bus_model: software side of the register port, one strobe a call.
// assumes callers run on sys_clk; every call starts at the next edge.
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write cycle; released lines show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read cycle; the data are taken by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

//--- test/test_hv_measure_switch_ctrl.sv
// test_hv_measure_switch_ctrl: self-checking bench for the switch control.
// assumes host_bus_model drives the register port; pins driven here.
`timescale 1ns/1ps
module test_hv_measure_switch_ctrl;
  import hv_meas_pkg::*;
  logic       sys_clk, nrst, sleep_cmd, sense_pin_in, multipin_in, fail_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
  logic       reg_wr, reg_rd, rd_q;
  logic       sw, rst_rq, slp_ok, f_out, m_drv, s_pu, s_pd, m_pu, m_pd;
  logic       s_q, m_q;
  chip_mode_t chip_mode;
  int         mismatches, compares, seed;
  logic [15:0] exp_q[$];  // {mask, expected} per read

  always #2.5 sys_clk = ~sys_clk;

  host_bus_model host_bus_model_i (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  hv_measure_switch_ctrl hv_measure_switch_ctrl_i (.sys_clk(sys_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .chip_mode(chip_mode), .sleep_cmd(sleep_cmd),
    .sense_pin_in(sense_pin_in), .multipin_in(multipin_in),
    .fail_req(fail_req), .pin_bridge_switch_ff(sw),
    .restart_req_ff(rst_rq), .sleep_ok_ff(slp_ok), .fail_out_ff(f_out),
    .multipin_drive_ff(m_drv), .sense_pull_up_ff(s_pu),
    .sense_pull_dn_ff(s_pd), .multi_pull_up_ff(m_pu),
    .multi_pull_dn_ff(m_pd), .sense_qual_ff(s_q), .multi_qual_ff(m_q));

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) chk("read queue", 8'h00, 8'hff);
      else begin
        logic [15:0] e;
        e = exp_q.pop_front();
        chk("read data", e[7:0], reg_rdata_ff & e[15:8]);
      end
    end
    rd_q <= reg_rd;
  end

  task automatic rdx(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    exp_q.push_back({m, e & m});
    host_bus_model_i.rd(a);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic pulls(input logic [3:0] e);
    chk("pulls", {4'h0, e}, {4'h0, m_pd, m_pu, s_pd, s_pu});
  endtask

  task automatic sleep_try(input logic exp_rst);
    @(posedge sys_clk);
    sleep_cmd <= 1'b1;
    @(posedge sys_clk);
    sleep_cmd <= 1'b0;
    #1;
    chk("restart pulse", {7'h0, exp_rst}, {7'h0, rst_rq});
    chk("sleep ok pulse", {7'h0, ~exp_rst}, {7'h0, slp_ok});
  endtask

  task automatic summarize;
    wait_n(3);
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize;
  end

  initial begin
    sys_clk = 1'b0; nrst = 1'b0; sleep_cmd = 1'b0; fail_req = 1'b0;
    sense_pin_in = 1'b0; multipin_in = 1'b0; chip_mode = mode_normal;
    mismatches = 0; compares = 0; seed = 70;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("switch in reset", 8'h00, {7'h0, sw});
    nrst <= 1'b1;
    wait_n(1);
    chk("switch after reset", 8'h00, {7'h0, sw});
    pulls(4'h0);
    rdx(meas_ctrl_addr, meas_ctrl_rst, 8'hff);
    rdx(multipin_addr, multipin_rst, 8'hff);
    rdx(wake_ctrl_addr, wake_ctrl_rst, 8'hff);
    rdx(8'h3c, 8'h00, 8'hff);
    $display("test reset done");

    // enable refused while the multipurpose pin is still a fail output
    host_bus_model_i.wr(meas_ctrl_addr, 8'h01);
    wait_n(3);
    chk("switch refused", 8'h00, {7'h0, sw});
    rdx(meas_ctrl_addr, 8'h00, 8'h01);
    rdx(status_addr, 8'h01, 8'h01);
    host_bus_model_i.wr(status_addr, 8'h01);
    rdx(status_addr, 8'h00, 8'h01);
    $display("test refusal done");

    // disabled: pulls and pin levels processed normally
    host_bus_model_i.wr(pull_cfg_addr, 8'h05);
    @(posedge sys_clk);
    sense_pin_in <= 1'b1;
    wait_n(4);
    pulls(4'h5);
    chk("sense qual", 8'h01, {7'h0, s_q});
    rdx(wake_lvl_addr, 8'h01, 8'h03);
    rdx(wake_stat0_addr, 8'h01, 8'h01);
    $display("test disabled done");

    // pin off first, then enable closes the switch in Normal
    host_bus_model_i.wr(multipin_addr, multipin_off);
    host_bus_model_i.wr(status_addr, 8'h01);
    host_bus_model_i.wr(meas_ctrl_addr, 8'h01);
    wait_n(3);
    chk("switch closed", 8'h01, {7'h0, sw});
    pulls(4'h0);
    host_bus_model_i.wr(pull_cfg_addr, 8'h0f);
    wait_n(3);
    pulls(4'h0);
    rdx(pull_cfg_addr, 8'h0f, 8'hff);
    // random pin activity must not reach the internal signals
    repeat (8) begin
      @(posedge sys_clk);
      sense_pin_in <= 1'($random(seed));
      multipin_in  <= 1'($random(seed));
      wait_n(2);
      chk("gated quals", 8'h00, {6'h0, m_q, s_q});
    end
    rdx(wake_lvl_addr, 8'h01, 8'h03);
    $display("test gating done");

    // no fail output or fail test while enabled
    @(posedge sys_clk);
    fail_req <= 1'b1;
    host_bus_model_i.wr(meas_ctrl_addr, 8'h03);
    wait_n(3);
    chk("fail out", 8'h00, {7'h0, f_out});
    chk("multipin drive", 8'h00, {7'h0, m_drv});
    host_bus_model_i.wr(multipin_addr, multipin_wake);
    rdx(status_addr, 8'h01, 8'h01);
    rdx(multipin_addr, {5'h0, multipin_wake}, 8'h07);
    wait_n(3);
    chk("drive as wake", 8'h00, {7'h0, m_drv});
    // fail output config while bridged: still no output with fail_req
    host_bus_model_i.wr(status_addr, 8'h01);
    host_bus_model_i.wr(multipin_addr, multipin_fo);
    rdx(status_addr, 8'h01, 8'h01);
    rdx(multipin_addr, {5'h0, multipin_fo}, 8'h07);
    wait_n(3);
    chk("fail out as fo", 8'h00, {7'h0, f_out});
    chk("drive as fo", 8'h00, {7'h0, m_drv});
    $display("test fail output done");

    // sleep with pin-only wake sources restarts and flags an error
    host_bus_model_i.wr(status_addr, 8'h01);
    host_bus_model_i.wr(wake_ctrl_addr, 8'h01);
    rdx(wake_ctrl_addr, 8'h01, 8'hff);
    sleep_try(1'b1);
    rdx(status_addr, 8'h01, 8'h01);
    host_bus_model_i.wr(wake_ctrl_addr, 8'h03);
    sleep_try(1'b0);
    $display("test sleep done");

    // switch only in Normal, setting kept in every mode
    for (int m = 0; m < 6; m++) begin
      @(posedge sys_clk);
      chip_mode <= chip_mode_t'(m);
      wait_n(3);
      chk("switch per mode", {7'h0, m == 1}, {7'h0, sw});
      rdx(meas_ctrl_addr, 8'h01, 8'h01);
    end
    @(posedge sys_clk);
    chip_mode <= mode_normal;
    wait_n(3);
    chk("switch back", 8'h01, {7'h0, sw});
    $display("test modes done");

    // disable: stored pull setting takes effect again
    host_bus_model_i.wr(meas_ctrl_addr, 8'h00);
    wait_n(3);
    chk("switch open", 8'h00, {7'h0, sw});
    pulls(4'hf);
    chk("fail out back", 8'h01, {7'h0, f_out});
    chk("drive back", 8'h01, {7'h0, m_drv});
    $display("test disable done");

    // fail-safe entry while disabled arms the sense pin as wake
    host_bus_model_i.wr(wake_ctrl_addr, 8'h00);
    host_bus_model_i.wr(wake_stat0_addr, 8'h00);
    rdx(wake_stat0_addr, 8'h00, 8'h01);
    @(posedge sys_clk);
    chip_mode <= mode_failsafe;
    wait_n(3);
    @(posedge sys_clk);
    sense_pin_in <= ~sense_pin_in;
    wait_n(3);
    rdx(wake_stat0_addr, 8'h01, 8'h01);
    $display("test fail-safe done");
    summarize;
  end
endmodule
